// [logic/mrs_pkg.sv]
// Constants, register map and timing for the reset sequencer
// Function
// - While reset is held, ports take initial values; release starts at reset vector.
// - Ports return to initial state asynchronously as soon as any source activates; here droop and watchdog act only through clocked flops.
// - After all sources go inactive, reset stretches for a fuse-selected period.
// - Exactly four sources: power-up, pin, watchdog, supply droop; any asserts reset.
// - Pin low beyond minimum width resets even without clock; shorter may not.
// - Pin rising starts the delay counter; release only after the stretch period.
// - Programmed pin-reset-disable fuse makes the device ignore the reset pin.
// - Power-up detection holds reset while supply is low, reasserting immediately.
// - Supply rising through power-up threshold starts the delay counter.
// - Three-bit level fuse: 111 disables, 110/101/100 pick levels, rest reserved.
// - Droop enabled: reset at once below lower trigger; count after upper trigger.
// - Droop dips shorter than the minimum duration are ignored.
// - Watchdog reset is one clock pulse; counting starts at its falling edge.
// - Watchdog expiry resets only when its system-reset mode is enabled.
// - Status bits 7..4 are read-only and always read zero.
// - Bit 3 set by watchdog reset; cleared by power-up or software zero.
// - Bit 2 set by droop reset; cleared by power-up or software zero.
// - Bit 1 set by pin reset; cleared by power-up or software zero.
// - Bit 0 set by power-up; only a software zero clears it.
// - Always-on fuse forces watchdog reset mode one and interrupt mode zero.
package mrs_pkg;

  // Register byte addresses
  localparam logic [3:0] STATUS_ADDR  = 4'h0;
  localparam logic [3:0] WDMODE_ADDR  = 4'h4;
  localparam logic [3:0] CONFIG_ADDR  = 4'h8;

  // Status field positions and reset value
  localparam int WATCHDOG_RESET_FLAG_BIT     = 3;
  localparam int SUPPLY_DROOP_RESET_FLAG_BIT = 2;
  localparam int PIN_RESET_FLAG_BIT          = 1;
  localparam int POWER_UP_FLAG_BIT           = 0;
  localparam logic [7:0] STATUS_RESET        = 8'h01;
  localparam logic [7:0] STATUS_USED_MASK    = 8'h0F;

  // Watchdog mode fields
  localparam int WD_IRQ_MODE_BIT   = 0;
  localparam int WD_RESET_MODE_BIT = 1;
  localparam logic [1:0] WDMODE_RESET = 2'h0;

  // Droop level fuse codes
  localparam logic [2:0] DROOP_OFF    = 3'h7;
  localparam logic [2:0] DROOP_LEVEL0 = 3'h6;
  localparam logic [2:0] DROOP_LEVEL1 = 3'h5;
  localparam logic [2:0] DROOP_LEVEL2 = 3'h4;

  // Reset vector address
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // Timing
  localparam int CLK_MHZ            = 25;
  localparam int DROOP_MIN_NS       = 2000;
  localparam int DROOP_MIN_CYC      = (DROOP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PIN_MIN_NS         = 2500;
  localparam int PIN_MIN_CYC        = (PIN_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int STRETCH_US0        = 64;
  localparam int STRETCH_US1        = 1024;
  localparam int STRETCH_US2        = 4096;
  localparam int STRETCH_US3        = 16384;
  localparam int CLOCK_SELECT_FUSE_STEP_US      = 16;
  localparam int STRETCH_W          = 24;

  typedef enum logic [1:0] {
    SEQ_HOLD  = 2'b00,
    SEQ_COUNT = 2'b01,
    SEQ_RUN   = 2'b11
  } mrs_state_t;

endpackage

// [logic/mrs_reset_sequencer.sv]
// Reset source combiner, stretch counter and cause register with Wishbone slave
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
module mrs_reset_sequencer
  import mrs_pkg::*;
#(
  parameter int STRETCH_CYC0 = STRETCH_US0 * CLK_MHZ,
  parameter int STRETCH_CYC1 = STRETCH_US1 * CLK_MHZ,
  parameter int STRETCH_CYC2 = STRETCH_US2 * CLK_MHZ,
  parameter int STRETCH_CYC3 = STRETCH_US3 * CLK_MHZ,
  parameter int CLOCK_SELECT_FUSE_STEP   = CLOCK_SELECT_FUSE_STEP_US * CLK_MHZ
)(
  input  wire logic        clk,
  input  wire logic        resetn,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Analog, pin and watchdog sources
  input  wire logic        vccAbovePowerUp,
  input  wire logic        resetPinN,
  input  wire logic        vccBelowDroop,
  input  wire logic        watchdogExpire,
  // Fuses
  input  wire logic        pinResetDisableFuse,
  input  wire logic [2:0]  droopTriggerLevelFuse,
  input  wire logic [1:0]  startupTimeFuse,
  input  wire logic [3:0]  clockSelectFuse,
  input  wire logic        watchdogAlwaysOnFuse,
  // Outputs
  output logic             droopEnable,
  output logic [1:0]       droopLevelSel,
  output logic             watchdogResetMode,
  output logic             watchdogIrqMode,
  output logic             portResetN,
  output logic             coreResetN,
  output logic             loadResetVector,
  output logic [15:0]      resetVector
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three flops, accept when second and third agree

  logic [2:0] asyncIn;
  logic [2:0] syncLevel;

  assign asyncIn = {vccBelowDroop, resetPinN, vccAbovePowerUp};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : gSync
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic lvl_reg;
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          s1_reg  <= 1'b0;
          s2_reg  <= 1'b0;
          s3_reg  <= 1'b0;
          lvl_reg <= 1'b0;
        end
        else
        begin
          s1_reg <= asyncIn[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg)
            lvl_reg <= s3_reg;
        end
      end
      assign syncLevel[gi] = lvl_reg;
    end
  endgenerate

  logic potOk;
  logic pinLowSync;
  logic belowDroopSync;

  assign potOk          = syncLevel[0];
  assign pinLowSync     = ~syncLevel[1] & ~pinResetDisableFuse;
  assign belowDroopSync = syncLevel[2];

  ////////////////////////////////////////////////////////////////////////////
  // Droop level decode

  logic droopOn;

  assign droopOn = (droopTriggerLevelFuse == DROOP_LEVEL0) |
                   (droopTriggerLevelFuse == DROOP_LEVEL1) |
                   (droopTriggerLevelFuse == DROOP_LEVEL2);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      droopEnable   <= 1'b0;
      droopLevelSel <= 2'h0;
    end
    else
    begin
      droopEnable   <= droopOn;
      droopLevelSel <= 2'(DROOP_LEVEL0 - droopTriggerLevelFuse);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Droop minimum-duration filter

  localparam int DMW = $clog2(DROOP_MIN_CYC + 1);
  localparam logic [DMW-1:0] DROOP_LIMIT = DMW'(DROOP_MIN_CYC);

  logic [DMW-1:0] droopCnt_reg;
  logic           droopActive_reg;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      droopCnt_reg    <= '0;
      droopActive_reg <= 1'b0;
    end
    else if (!droopOn || !belowDroopSync)
    begin
      droopCnt_reg    <= '0;
      droopActive_reg <= 1'b0;
    end
    else if (droopCnt_reg != DROOP_LIMIT)
      droopCnt_reg <= droopCnt_reg + 1'b1;
    else
      droopActive_reg <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin minimum-width qualification for the cause flag

  localparam int PMW = $clog2(PIN_MIN_CYC + 1);
  localparam logic [PMW-1:0] PIN_LIMIT = PMW'(PIN_MIN_CYC);

  logic [PMW-1:0] pinCnt_reg;
  logic           pinValid;

  assign pinValid = pinLowSync & (pinCnt_reg == PIN_LIMIT);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pinCnt_reg <= '0;
    else if (!pinLowSync)
      pinCnt_reg <= '0;
    else if (pinCnt_reg != PIN_LIMIT)
      pinCnt_reg <= pinCnt_reg + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog mode register and one-cycle reset pulse

  logic [1:0] wdMode_reg;
  logic       wdResetModeEff;
  logic       wdIrqModeEff;
  logic       wdPulse_reg;
  logic       wdExpPrev_reg;

  assign wdResetModeEff = watchdogAlwaysOnFuse | wdMode_reg[WD_RESET_MODE_BIT];
  assign wdIrqModeEff   = ~watchdogAlwaysOnFuse & wdMode_reg[WD_IRQ_MODE_BIT];
  assign watchdogResetMode = wdResetModeEff;
  assign watchdogIrqMode   = wdIrqModeEff;

  // One pulse per rising time-out in reset mode, even for a held level
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wdPulse_reg   <= 1'b0;
      wdExpPrev_reg <= 1'b0;
    end
    else
    begin
      wdPulse_reg   <= watchdogExpire & ~wdExpPrev_reg & wdResetModeEff;
      wdExpPrev_reg <= watchdogExpire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source combination

  logic asyncSource;
  logic syncSource;

  // Comparator and pin reach the port reset with no clock involved
  assign asyncSource = ~vccAbovePowerUp |
                       (~resetPinN & ~pinResetDisableFuse) |
                       droopActive_reg | wdPulse_reg;
  assign syncSource  = ~potOk | pinLowSync | droopActive_reg | wdPulse_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Stretch counter

  logic [STRETCH_W-1:0] stretchBase;
  logic [STRETCH_W-1:0] stretchTarget;
  logic [STRETCH_W-1:0] stretchCnt_reg;
  logic [STRETCH_W-1:0] stretchCnt_next;
  mrs_state_t           seq_reg;
  mrs_state_t           seq_next;
  logic                 stretchDone;

  assign stretchBase = (startupTimeFuse == 2'h0) ? STRETCH_W'(STRETCH_CYC0) :
                       (startupTimeFuse == 2'h1) ? STRETCH_W'(STRETCH_CYC1) :
                       (startupTimeFuse == 2'h2) ? STRETCH_W'(STRETCH_CYC2) :
                                                   STRETCH_W'(STRETCH_CYC3);
  assign stretchTarget = stretchBase +
                         STRETCH_W'(CLOCK_SELECT_FUSE_STEP * int'(clockSelectFuse));
  assign stretchDone = (stretchCnt_reg + 1'b1 >= stretchTarget);

  always_comb
  begin
    seq_next        = seq_reg;
    stretchCnt_next = stretchCnt_reg;
    case (seq_reg)
      SEQ_HOLD:
      begin
        stretchCnt_next = '0;
        if (!syncSource)
          seq_next = SEQ_COUNT;
      end
      SEQ_COUNT:
      begin
        if (syncSource)
        begin
          seq_next        = SEQ_HOLD;
          stretchCnt_next = '0;
        end
        else if (stretchDone)
          seq_next = SEQ_RUN;
        else
          stretchCnt_next = stretchCnt_reg + 1'b1;
      end
      SEQ_RUN:
      begin
        stretchCnt_next = '0;
        if (syncSource)
          seq_next = SEQ_HOLD;
      end
      default:
      begin
        seq_next        = SEQ_HOLD;
        stretchCnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      seq_reg        <= SEQ_HOLD;
      stretchCnt_reg <= '0;
    end
    else
    begin
      seq_reg        <= seq_next;
      stretchCnt_reg <= stretchCnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset outputs and vector load

  logic released;

  assign released   = (seq_reg == SEQ_RUN);
  assign portResetN = released & ~asyncSource;
  assign coreResetN = released & ~asyncSource;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      loadResetVector <= 1'b0;
      resetVector     <= RESET_VECTOR;
    end
    else
    begin
      loadResetVector <= (seq_reg == SEQ_COUNT) & (seq_next == SEQ_RUN);
      resetVector     <= RESET_VECTOR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone decode

  logic       busReq;
  logic       busWrite;
  logic       hitStatus;
  logic       hitWdMode;
  logic       hitConfig;
  logic       wrStatus;
  logic       wrWdMode;

  assign busReq    = cyc_i & stb_i & ~ack_o;
  assign busWrite  = busReq & we_i & sel_i[0];
  assign hitStatus = (adr_i == STATUS_ADDR);
  assign hitWdMode = (adr_i == WDMODE_ADDR);
  assign hitConfig = (adr_i == CONFIG_ADDR);
  assign wrStatus  = busWrite & hitStatus;
  assign wrWdMode  = busWrite & hitWdMode & ~watchdogAlwaysOnFuse;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wdMode_reg <= WDMODE_RESET;
    else if (wrWdMode)
      wdMode_reg <= dat_i[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause register

  logic [7:0] resetCauseStatus_reg;
  logic [7:0] resetCauseStatus_next;
  logic [7:0] causeSet;
  logic [7:0] causeKeep;

  assign causeSet = {4'h0,
                     wdPulse_reg,
                     droopActive_reg,
                     pinValid,
                     ~potOk};
  // Writing zero clears, one leaves alone; power-up wipes the others
  assign causeKeep = (wrStatus ? dat_i[7:0] : 8'hFF) &
                     (potOk ? 8'hFF : 8'h01);
  assign resetCauseStatus_next = ((resetCauseStatus_reg & causeKeep) | causeSet) &
                                 STATUS_USED_MASK;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      resetCauseStatus_reg <= STATUS_RESET;
    else
      resetCauseStatus_reg <= resetCauseStatus_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and acknowledge

  logic [31:0] readMux;

  assign readMux = hitStatus ? {24'h0, resetCauseStatus_reg} :
                   hitWdMode ? {30'h0, wdResetModeEff, wdIrqModeEff} :
                   hitConfig ? {17'h0, seq_reg, droopActive_reg, ~potOk,
                                watchdogAlwaysOnFuse, pinResetDisableFuse,
                                droopTriggerLevelFuse, clockSelectFuse,
                                startupTimeFuse} :
                               32'h0;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end
    else
    begin
      ack_o <= busReq;
      if (busReq && !we_i)
        dat_o <= readMux;
    end
  end

endmodule

// [tb/mrs_reset_sequencer_assertions.sv]
// Port checks for the reset sequencer
module mrs_reset_sequencer_assertions
  import mrs_pkg::*;
#(
  parameter int STRETCH_CYC0 = 8,
  parameter int STRETCH_CYC1 = 16,
  parameter int STRETCH_CYC2 = 32,
  parameter int STRETCH_CYC3 = 64,
  parameter int CLOCK_SELECT_FUSE_STEP   = 1
)(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        vccAbovePowerUp,
  input wire logic        resetPinN,
  input wire logic        watchdogExpire,
  input wire logic        pinResetDisableFuse,
  input wire logic [2:0]  droopTriggerLevelFuse,
  input wire logic [1:0]  startupTimeFuse,
  input wire logic [3:0]  clockSelectFuse,
  input wire logic        watchdogAlwaysOnFuse,
  input wire logic        droopEnable,
  input wire logic [1:0]  droopLevelSel,
  input wire logic        watchdogResetMode,
  input wire logic        watchdogIrqMode,
  input wire logic        portResetN,
  input wire logic        coreResetN,
  input wire logic        loadResetVector,
  input wire logic [15:0] resetVector
);
  timeunit 1ns;
  timeprecision 1ps;
  logic quiet;
  int   tgt;
  int   quietCnt;
  assign quiet = vccAbovePowerUp && (resetPinN || pinResetDisableFuse);
  assign tgt = CLOCK_SELECT_FUSE_STEP * clockSelectFuse + (startupTimeFuse == 2'h0 ? STRETCH_CYC0 :
    startupTimeFuse == 2'h1 ? STRETCH_CYC1 : startupTimeFuse == 2'h2 ? STRETCH_CYC2 : STRETCH_CYC3);
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) quietCnt <= 0;
    else quietCnt <= quiet ? (quietCnt < 9999 ? quietCnt + 1 : quietCnt) : 0;
  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_wd_fire;
    $rose(watchdogExpire) && watchdogResetMode;
  endsequence
  sequence s_release;
    $rose(coreResetN);
  endsequence
  a_pin_async: assert property (!resetPinN && !pinResetDisableFuse |-> !portResetN)
    else $error("pin low without port reset");
  a_power_low: assert property (!vccAbovePowerUp |-> !coreResetN && !portResetN)
    else $error("low supply without reset");
  a_ports_follow: assert property (!coreResetN |-> !portResetN)
    else $error("ports free during reset");
  a_vector_pulse: assert property (loadResetVector |->
    coreResetN && resetVector == RESET_VECTOR ##1 !loadResetVector)
    else $error("bad vector load");
  a_stretch_min: assert property (s_release |-> quietCnt >= tgt)
    else $error("reset released early");
  a_wd_fire: assert property (s_wd_fire |-> ##[1:3] !coreResetN)
    else $error("watchdog reset missing");
  a_wd_masked: assert property ($rose(watchdogExpire) && !watchdogResetMode && quiet
    && coreResetN |=> coreResetN [*3]) else $error("masked watchdog reset");
  a_wd_locked: assert property (watchdogAlwaysOnFuse |-> watchdogResetMode && !watchdogIrqMode)
    else $error("watchdog mode not forced");
  a_droop_code: assert property (droopTriggerLevelFuse inside {3'h4, 3'h5, 3'h6} |=>
    droopEnable && droopLevelSel == ($past(droopTriggerLevelFuse) == DROOP_LEVEL0 ? 2'h0 :
    $past(droopTriggerLevelFuse) == DROOP_LEVEL1 ? 2'h1 : 2'h2))
    else $error("droop level decode");
  a_droop_off: assert property (!(droopTriggerLevelFuse inside {3'h4, 3'h5, 3'h6}) |=> !droopEnable)
    else $error("droop enabled by bad code");
  a_status_top: assert property (ack_o && !we_i && adr_i == STATUS_ADDR |-> dat_o[31:4] == 28'h0)
    else $error("status upper bits set");
endmodule
////////////////////////////////////////
bind mrs_reset_sequencer mrs_reset_sequencer_assertions #(
  .STRETCH_CYC0(STRETCH_CYC0), .STRETCH_CYC1(STRETCH_CYC1), .STRETCH_CYC2(STRETCH_CYC2),
  .STRETCH_CYC3(STRETCH_CYC3), .CLOCK_SELECT_FUSE_STEP(CLOCK_SELECT_FUSE_STEP)) u_chk (
  .clk(clk), .resetn(resetn), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .vccAbovePowerUp(vccAbovePowerUp), .resetPinN(resetPinN), .watchdogExpire(watchdogExpire),
  .pinResetDisableFuse(pinResetDisableFuse), .droopTriggerLevelFuse(droopTriggerLevelFuse),
  .startupTimeFuse(startupTimeFuse), .clockSelectFuse(clockSelectFuse),
  .watchdogAlwaysOnFuse(watchdogAlwaysOnFuse), .droopEnable(droopEnable),
  .droopLevelSel(droopLevelSel), .watchdogResetMode(watchdogResetMode),
  .watchdogIrqMode(watchdogIrqMode), .portResetN(portResetN), .coreResetN(coreResetN),
  .loadResetVector(loadResetVector), .resetVector(resetVector)
);

// [tb/mrs_source_model.sv]
// Supply monitors, reset pin and watchdog driving the sequencer
module mrs_source_model
(
  input  wire logic clk,
  output logic      vccAbovePowerUp,
  output logic      resetPinN,
  output logic      vccBelowDroop,
  output logic      watchdogExpire
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    vccAbovePowerUp = 1'b0;
    resetPinN = 1'b1;
    vccBelowDroop = 1'b0;
    watchdogExpire = 1'b0;
  end
  task automatic supply(input logic on);
    vccAbovePowerUp <= on;
  endtask
  task automatic pin(input int n);
    resetPinN <= 1'b0;
    repeat (n) @(posedge clk);
    resetPinN <= 1'b1;
  endtask
  task automatic droop(input int n);
    vccBelowDroop <= 1'b1;
    repeat (n) @(posedge clk);
    vccBelowDroop <= 1'b0;
  endtask
  // One clock time-out pulse
  task automatic wdog();
    watchdogExpire <= 1'b1;
    @(posedge clk);
    watchdogExpire <= 1'b0;
  endtask
endmodule

// [tb/mrs_reset_sequencer_tb.sv]
// Self-checking bench for the reset sequencer
module mrs_reset_sequencer_tb
  import mrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, cyc, stb, we, ack, pinDis, wdOn, vccUp, pinN, vccLow, wdExp;
  logic        drEn, wdRst, wdIrq, portN, coreResetN, ldVec;
  logic [1:0]  startup_time_fuse, drSel;
  logic [2:0]  lvl;
  logic [3:0]  adr, sel, cks;
  logic [15:0] vec;
  logic [31:0] dat, datO;
  int          numErrors = 0;
  int          nCompared = 0;
  int          cycles = 0;
  localparam int SC0  = 8;
  localparam int SC1  = 16;
  localparam int SC2  = 32;
  localparam int SC3  = 64;
  localparam int STEP = 1;
  mrs_reset_sequencer #(.STRETCH_CYC0(SC0), .STRETCH_CYC1(SC1), .STRETCH_CYC2(SC2),
    .STRETCH_CYC3(SC3), .CLOCK_SELECT_FUSE_STEP(STEP)) dut (
    .clk(clk), .resetn(resetn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(datO), .ack_o(ack), .vccAbovePowerUp(vccUp),
    .resetPinN(pinN), .vccBelowDroop(vccLow), .watchdogExpire(wdExp),
    .pinResetDisableFuse(pinDis), .droopTriggerLevelFuse(lvl), .startupTimeFuse(startup_time_fuse),
    .clockSelectFuse(cks), .watchdogAlwaysOnFuse(wdOn), .droopEnable(drEn),
    .droopLevelSel(drSel), .watchdogResetMode(wdRst), .watchdogIrqMode(wdIrq),
    .portResetN(portN), .coreResetN(coreResetN), .loadResetVector(ldVec), .resetVector(vec));
  mrs_source_model src (.clk(clk), .vccAbovePowerUp(vccUp), .resetPinN(pinN),
    .vccBelowDroop(vccLow), .watchdogExpire(wdExp));
  ////////////////////////////////////////
  task automatic conclude();
    $display("Compared %0d, errors %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nCompared++;
    if (g !== e)
    begin
      numErrors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int t;
    t = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat <= {24'h0, d};
    do
    begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1);
    q = datO;
    cyc <= 1'b0; stb <= 1'b0;
    chk("ack wait", 32'd2, t);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string nm);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, 4'hF, q);
    chk(nm, e, q & m);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rel(input int tgt, input string nm);
    int n;
    n = 0;
    while (coreResetN !== 1'b1 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    chk(nm, 32'h1, 32'(n >= tgt && n <= tgt + 8));
    chk("vector load", 32'h1, ldVec);
    chk("vector", 32'(RESET_VECTOR), vec);
  endtask
  task automatic hold(input int n, input string nm);
    int b;
    b = 0;
    repeat (n)
    begin
      @(posedge clk);
      if (coreResetN !== 1'b1) b = 1;
    end
    chk(nm, 32'h0, b);
  endtask
  ////////////////////////////////////////
  task automatic tStartup();
    resetn <= 1'b1;
    src.supply(1'b1);
    rel(SC0, "startup stretch");
    rd(STATUS_ADDR, 32'hFF, 32'h01, "status");
    rd(4'hC, 32'hFFFFFFFF, 32'h0, "unmapped");
    rd(CONFIG_ADDR, 32'h603F, 32'h6000, "config");
  endtask
  task automatic tPin();
    startup_time_fuse <= 2'h1;
    cks <= 4'h2;
    fork
      src.pin(70);
      begin @(negedge clk); chk("port reset", 32'h0, portN); end
    join
    repeat (4) @(posedge clk);
    src.pin(3);
    rel(SC1 + 2 * STEP, "pin stretch");
    rd(STATUS_ADDR, 32'hFF, 32'h03, "pin flag");
    wr(STATUS_ADDR, 8'h00);
    rd(STATUS_ADDR, 32'hFF, 32'h00, "cleared");
  endtask
  task automatic tPinOff();
    pinDis <= 1'b1;
    fork src.pin(70); hold(75, "pin ignored"); join
    pinDis <= 1'b0;
    rd(STATUS_ADDR, 32'hFF, 32'h00, "no pin flag");
  endtask
  task automatic tWatchdog();
    logic [31:0] q;
    startup_time_fuse <= 2'h2;
    cks <= 4'h0;
    wr(WDMODE_ADDR, 8'h00);
    fork src.wdog(); hold(10, "wd masked"); join
    wr(WDMODE_ADDR, 8'h02);
    src.wdog();
    @(negedge clk);
    chk("wd reset", 32'h0, coreResetN);
    rel(SC2, "wd stretch");
    rd(STATUS_ADDR, 32'hFF, 32'h08, "wd flag");
    wb(1'b1, STATUS_ADDR, 8'h00, 4'hE, q);
    rd(STATUS_ADDR, 32'hFF, 32'h08, "lane off");
    wr(STATUS_ADDR, 8'h00);
    wr(WDMODE_ADDR, 8'h00);
  endtask
  task automatic tDroop();
    for (int c = 0; c < 8; c++)
    begin
      lvl <= 3'(c);
      repeat (3) @(posedge clk);
      chk("droop en", 32'(c inside {4, 5, 6}), drEn);
      if (c inside {4, 5, 6}) chk("droop sel", 32'(6 - c), drSel);
    end
    fork src.droop(60); hold(65, "droop off"); join
    lvl <= DROOP_LEVEL0;
    repeat (3) @(posedge clk);
    fork src.droop(10); hold(30, "short dip"); join
    src.droop(60);
    @(negedge clk);
    chk("droop reset", 32'h0, coreResetN);
    rel(SC2, "droop stretch");
    rd(STATUS_ADDR, 32'hFF, 32'h04, "droop flag");
    wr(STATUS_ADDR, 8'h00);
    lvl <= DROOP_OFF;
  endtask
  task automatic tLock();
    wdOn <= 1'b1;
    wr(WDMODE_ADDR, 8'h01);
    rd(WDMODE_ADDR, 32'h3, 32'h2, "mode locked");
    chk("reset mode pin", 32'h1, wdRst);
    chk("irq mode pin", 32'h0, wdIrq);
    wdOn <= 1'b0;
    rd(WDMODE_ADDR, 32'h3, 32'h0, "mode kept");
  endtask
  task automatic tPower();
    startup_time_fuse <= 2'h3;
    cks <= 4'h1;
    src.pin(70);
    rel(SC3 + STEP, "pin again");
    src.supply(1'b0);
    @(negedge clk);
    chk("power reset", 32'h0, coreResetN);
    repeat (5) @(posedge clk);
    src.supply(1'b1);
    rel(SC3 + STEP, "power stretch");
    rd(STATUS_ADDR, 32'hFF, 32'h01, "power flags");
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      numErrors++;
      conclude();
    end
  end
  initial
  begin
    resetn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'hF;
    dat = 32'h0; pinDis = 1'b0; lvl = 3'h7; startup_time_fuse = 2'h0; cks = 4'h0; wdOn = 1'b0;
    repeat (4) @(posedge clk);
    tStartup();
    tPin();
    tPinOff();
    tWatchdog();
    tDroop();
    tLock();
    tPower();
    conclude();
  end
endmodule
